// file: inc/cps_pkg.sv
// Constants and types of the program sequencer
// Summary of operation
// - Instruction address advances by instruction length
// - Taken branch loads operand target address
// - Call saves return address, then jumps
// - Return restores saved return address
// - Reset sets instruction address to zero
// - One-bit depth: call up, return down
// - Depth overflow or underflow forces system reset
// - No direct write path to depth
// - 11-bit return stack, low byte shares last word
// - Reset leaves return stack untouched
// - Touching last word spoils stack upper bits
// - Program memory gives 10-bit word per step
// - Test region access redirects to zero
// - 4-bit data words, also paired as bytes
// - Reset clears data word zero only
// - Table pointer: control high nibble, word zero
// - Table pointer reads zero after reset
// - Accumulator has no reset
package cps_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int IA_W = 11;
  localparam int TP_W = 12;
  localparam int PW_W = 10;
  localparam int NIB_W = 4;
  localparam int DM_DEPTH = 32;
  localparam int DM_IDX_W = 5;
  localparam int STK_HI_W = IA_W - 8;

  // ---------------------------------------------------------------
  // Reset values and fixed addresses
  // ---------------------------------------------------------------
  localparam logic [IA_W-1:0] IA_RST = 11'h000;
  localparam logic [TP_W-1:0] TEST_BASE = 12'h07ea;
  localparam logic [IA_W-1:0] BR_LEN = 11'h002;
  localparam logic [IA_W-1:0] PLAIN_LEN = 11'h001;
  localparam logic [7:0] WORD_ZERO_RST = 8'h00;
  localparam logic [NIB_W-1:0] CTRL_HI_RST = 4'h0;
  localparam logic [STK_HI_W-1:0] STK_HI_POISON = 3'h7;
  localparam logic [3:0] LAST_PAIR = 4'hf;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [5:0] OFS_CMD = 6'h00;
  localparam logic [5:0] OFS_OPERAND = 6'h04;
  localparam logic [5:0] OFS_INSTR = 6'h08;
  localparam logic [5:0] OFS_STATUS = 6'h0c;
  localparam logic [5:0] OFS_ACC = 6'h10;
  localparam logic [5:0] OFS_TABLE_PTR = 6'h14;
  localparam logic [5:0] OFS_FETCH = 6'h18;
  localparam logic [5:0] OFS_TABLE_DATA = 6'h1c;
  localparam logic [5:0] OFS_RET_STACK = 6'h20;
  localparam logic [5:0] OFS_MEM_DATA = 6'h24;
  localparam logic [5:0] OFS_CTRL_ZERO = 6'h28;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ST_DEPTH_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_HANG_BIT = 2;
  localparam int ST_TEST_BIT = 3;
  localparam int MEM4_DATA_LSB = 8;
  localparam int MEM8_DATA_LSB = 4;
  localparam int CTRL_HI_LSB = 4;

  // ---------------------------------------------------------------
  // Commands and states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_STEP = 4'h1,
    OP_BRANCH_ALWAYS = 4'h2,
    OP_BRANCH_IF_CARRY = 4'h3,
    OP_BRANCH_IF_NO_CARRY = 4'h4,
    OP_BRANCH_IF_FLAG = 4'h5,
    OP_BRANCH_IF_NO_FLAG = 4'h6,
    OP_CALL = 4'h7,
    OP_RET = 4'h8,
    OP_TABLE = 4'h9,
    OP_WR4 = 4'ha,
    OP_RD4 = 4'hb,
    OP_WR8 = 4'hc,
    OP_RD8 = 4'hd,
    OP_ACC_LOAD = 4'he,
    OP_ACC_FROM_MEM = 4'hf
  } cps_op_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_FETCH = 3'b100
  } cps_state_type;

endpackage : cps_pkg

// file: hdl/cps_data_mem.sv
// Data memory of 32 nibbles with paired byte access
`timescale 1ns/10ps
module cps_data_mem (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic soft_rst,
  // Nibble access
  input wire logic wr4_en,
  input wire logic [cps_pkg::DM_IDX_W-1:0] wr4_idx,
  input wire logic [cps_pkg::NIB_W-1:0] wr4_data,
  input wire logic [cps_pkg::DM_IDX_W-1:0] rd4_idx,
  output logic [cps_pkg::NIB_W-1:0] rd4_data,
  // Pair access
  input wire logic wr8_en,
  input wire logic [3:0] wr8_idx,
  input wire logic [7:0] wr8_data,
  input wire logic [3:0] rd8_idx,
  output logic [7:0] rd8_data,
  // Return stack low byte and pointer byte
  input wire logic stk_en,
  input wire logic [7:0] stk_data,
  output logic [7:0] pair_zero,
  output logic [7:0] pair_last
);
  import cps_pkg::*;

  logic [NIB_W-1:0] mem [DM_DEPTH];

  assign rd4_data = mem[rd4_idx];
  assign rd8_data = {mem[{1'b1, rd8_idx}], mem[{1'b0, rd8_idx}]};
  assign pair_zero = {mem[16], mem[0]};
  assign pair_last = {mem[31], mem[15]};

  // Only pair zero resets; the rest keeps its content across reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem[0] <= WORD_ZERO_RST[3:0];
      mem[16] <= WORD_ZERO_RST[7:4];
    end else if (soft_rst) begin
      mem[0] <= WORD_ZERO_RST[3:0];
      mem[16] <= WORD_ZERO_RST[7:4];
    end else begin
      if (wr4_en) begin
        mem[wr4_idx] <= wr4_data;
      end
      if (wr8_en) begin
        mem[{1'b0, wr8_idx}] <= wr8_data[3:0];
        mem[{1'b1, wr8_idx}] <= wr8_data[7:4];
      end
      if (stk_en) begin
        mem[15] <= stk_data[3:0];
        mem[31] <= stk_data[7:4];
      end
    end
  end

endmodule : cps_data_mem

// file: hdl/cps_ret_stack.sv
// Return stack upper bits and one-bit depth with fault detection
`timescale 1ns/10ps
module cps_ret_stack (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic soft_rst,
  // Stack requests
  input wire logic push,
  input wire logic pop,
  input wire logic [cps_pkg::STK_HI_W-1:0] push_hi,
  input wire logic touch_last,
  // State
  output logic stack_depth,
  output logic [cps_pkg::STK_HI_W-1:0] stack_hi,
  output logic fault
);
  import cps_pkg::*;

  // A second call or an unmatched return means the program is lost
  assign fault = (push & stack_depth) | (pop & ~stack_depth);

  // Only call, return and reset move the depth
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_depth <= 1'b0;
    end else if (soft_rst) begin
      stack_depth <= 1'b0;
    end else if (push) begin
      stack_depth <= 1'b1;
    end else if (pop) begin
      stack_depth <= 1'b0;
    end
  end

  // No reset here: the saved address survives any reset
  always_ff @(posedge sys_clk) begin
    if (push & ~fault) begin
      stack_hi <= push_hi;
    end else if (touch_last) begin
      stack_hi <= STK_HI_POISON;
    end
  end

endmodule : cps_ret_stack

// file: hdl/cps_sequencer.sv
// Program sequencer and register core with Avalon-MM access
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module cps_sequencer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Program memory
  output logic [cps_pkg::TP_W-1:0] prog_addr,
  input wire logic [cps_pkg::PW_W-1:0] prog_data,
  // Branch conditions
  input wire logic carry_flag,
  input wire logic status_flag,
  // System reset from stack fault
  output logic hang_reset
);
  import cps_pkg::*;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  cps_state_type state;
  cps_state_type next_state;
  cps_op_type op;
  logic [IA_W-1:0] instr_addr;
  logic [TP_W-1:0] operand;
  logic [NIB_W-1:0] acc;
  logic [NIB_W-1:0] ctrl_zero_hi;
  logic [PW_W-1:0] fetch_word;
  logic [PW_W-1:0] table_data;
  logic [7:0] mem_data;
  logic hang_flag;
  logic test_flag;
  logic rd_ack;

  // ---------------------------------------------------------------
  // Submodule outputs
  // ---------------------------------------------------------------
  logic [NIB_W-1:0] rd4_data;
  logic [7:0] rd8_data;
  logic [7:0] pair_zero;
  logic [7:0] pair_last;
  logic stack_depth;
  logic [STK_HI_W-1:0] stack_hi;
  logic stk_fault;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic in_test(input logic [TP_W-1:0] addr);
    in_test = addr >= TEST_BASE;
  endfunction : in_test

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire sel_cmd = avs_address == OFS_CMD;
  wire sel_operand = avs_address == OFS_OPERAND;
  wire sel_instr = avs_address == OFS_INSTR;
  wire sel_status = avs_address == OFS_STATUS;
  wire sel_acc = avs_address == OFS_ACC;
  wire sel_tp = avs_address == OFS_TABLE_PTR;
  wire sel_fetch = avs_address == OFS_FETCH;
  wire sel_tdata = avs_address == OFS_TABLE_DATA;
  wire sel_stack = avs_address == OFS_RET_STACK;
  wire sel_mdata = avs_address == OFS_MEM_DATA;
  wire sel_ctrl = avs_address == OFS_CTRL_ZERO;

  wire is_idle = state == ST_IDLE;
  wire in_exec = state == ST_EXEC;

  // Inputs of a running command are held off until it finishes
  wire sel_hold = sel_cmd | sel_operand | sel_ctrl;
  wire wr_stall = avs_write & sel_hold & ~is_idle;
  assign avs_waitrequest = (avs_read & ~rd_ack) | wr_stall;
  wire wr_go = avs_write & ~wr_stall;

  wire cmd_take = wr_go & sel_cmd & avs_byteenable[0];
  wire take_table = cmd_take & (avs_writedata[3:0] == OP_TABLE);
  wire status_wr = wr_go & sel_status & avs_byteenable[0];
  wire hang_clr = status_wr & avs_writedata[ST_HANG_BIT];
  wire test_clr = status_wr & avs_writedata[ST_TEST_BIT];

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  wire op_step = op == OP_STEP;
  wire op_call = op == OP_CALL;
  wire op_ret = op == OP_RET;
  wire op_table = op == OP_TABLE;
  wire op_wr4 = op == OP_WR4;
  wire op_rd4 = op == OP_RD4;
  wire op_wr8 = op == OP_WR8;
  wire op_rd8 = op == OP_RD8;
  wire op_acc_mem = op == OP_ACC_FROM_MEM;
  wire is_branch = (op >= OP_BRANCH_ALWAYS) && (op <= OP_BRANCH_IF_NO_FLAG);
  wire is_mem4 = op_wr4 | op_rd4 | op_acc_mem;
  wire is_mem = is_mem4 | op_wr8 | op_rd8;

  wire br_taken = (op == OP_BRANCH_ALWAYS) |
                  ((op == OP_BRANCH_IF_CARRY) & carry_flag) |
                  ((op == OP_BRANCH_IF_NO_CARRY) & ~carry_flag) |
                  ((op == OP_BRANCH_IF_FLAG) & status_flag) |
                  ((op == OP_BRANCH_IF_NO_FLAG) & ~status_flag);

  // ---------------------------------------------------------------
  // Next instruction address
  // ---------------------------------------------------------------
  wire [IA_W-1:0] step_len = op_step ? IA_W'(operand[1:0]) :
                             (is_branch | op_call) ? BR_LEN : PLAIN_LEN;
  wire [IA_W-1:0] seq_addr = IA_W'(instr_addr + step_len);
  wire [IA_W-1:0] ret_addr = IA_W'(instr_addr + BR_LEN);
  wire [IA_W-1:0] stack_addr = {stack_hi, pair_last};
  wire [TP_W-1:0] table_ptr = {ctrl_zero_hi, pair_zero};

  wire [IA_W-1:0] raw_next = (br_taken | op_call) ? operand[IA_W-1:0] :
                             op_ret ? stack_addr :
                             op_table ? instr_addr :
                             seq_addr;

  wire push = in_exec & op_call;
  wire pop = in_exec & op_ret;
  wire soft_rst = in_exec & stk_fault;
  wire tp_test = in_test(table_ptr);
  wire ia_test = in_test({1'b0, raw_next});
  wire test_hit = in_exec & (op_table ? tp_test : ia_test);

  wire [IA_W-1:0] next_instr_addr = (soft_rst | test_hit) ? IA_RST : raw_next;
  wire touch_last = in_exec & is_mem & (operand[3:0] == LAST_PAIR);

  // ---------------------------------------------------------------
  // Sequencing state
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (cmd_take) begin
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        next_state = ST_FETCH;
      end
      ST_FETCH: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      op <= OP_NOP;
    end else if (cmd_take) begin
      op <= cps_op_type'(avs_writedata[3:0]);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      operand <= '0;
    end else if (wr_go & sel_operand) begin
      if (avs_byteenable[0]) begin
        operand[7:0] <= avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        operand[TP_W-1:8] <= avs_writedata[TP_W-1:8];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_addr <= IA_RST;
    end else if (in_exec) begin
      instr_addr <= next_instr_addr;
    end
  end

  // ---------------------------------------------------------------
  // Program memory port
  // ---------------------------------------------------------------
  // Table reads borrow the port for one cycle, then it returns to code
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_addr <= {1'b0, IA_RST};
    end else if (take_table) begin
      prog_addr <= table_ptr;
    end else if (in_exec) begin
      prog_addr <= {1'b0, next_instr_addr};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_word <= '0;
    end else if (!in_exec) begin
      fetch_word <= prog_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      table_data <= '0;
    end else if (in_exec & op_table & ~tp_test) begin
      table_data <= prog_data;
    end
  end

  // ---------------------------------------------------------------
  // Accumulator, data path and control nibble
  // ---------------------------------------------------------------
  // No reset: software must load it before use
  always_ff @(posedge sys_clk) begin
    if (in_exec & (op == OP_ACC_LOAD)) begin
      acc <= operand[NIB_W-1:0];
    end else if (in_exec & op_acc_mem) begin
      acc <= rd4_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_data <= '0;
    end else if (in_exec & op_rd4) begin
      mem_data <= {4'h0, rd4_data};
    end else if (in_exec & op_rd8) begin
      mem_data <= rd8_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_zero_hi <= CTRL_HI_RST;
    end else if (soft_rst) begin
      ctrl_zero_hi <= CTRL_HI_RST;
    end else if (wr_go & sel_ctrl & avs_byteenable[0]) begin
      ctrl_zero_hi <= avs_writedata[CTRL_HI_LSB +: NIB_W];
    end
  end

  // ---------------------------------------------------------------
  // Sticky status, set wins over clear
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hang_flag <= 1'b0;
      test_flag <= 1'b0;
      hang_reset <= 1'b0;
    end else begin
      hang_reset <= soft_rst;
      if (soft_rst) begin
        hang_flag <= 1'b1;
      end else if (hang_clr) begin
        hang_flag <= 1'b0;
      end
      if (test_hit) begin
        test_flag <= 1'b1;
      end else if (test_clr) begin
        test_flag <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [31:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[ST_DEPTH_BIT] = stack_depth;
    status_word[ST_BUSY_BIT] = ~is_idle;
    status_word[ST_HANG_BIT] = hang_flag;
    status_word[ST_TEST_BIT] = test_flag;
  end

  // Unmapped and write-only offsets read as zero
  wire [31:0] rd_mux = sel_operand ? 32'(operand) :
                       sel_instr ? 32'(instr_addr) :
                       sel_status ? status_word :
                       sel_acc ? 32'(acc) :
                       sel_tp ? 32'(table_ptr) :
                       sel_fetch ? 32'(fetch_word) :
                       sel_tdata ? 32'(table_data) :
                       sel_stack ? 32'(stack_addr) :
                       sel_mdata ? 32'(mem_data) :
                       sel_ctrl ? 32'({ctrl_zero_hi, 4'h0}) :
                       32'h0000_0000;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_ack <= avs_read & ~rd_ack;
      if (avs_read & ~rd_ack) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // ---------------------------------------------------------------
  // Data memory and return stack
  // ---------------------------------------------------------------
  cps_data_mem u_data_mem (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .soft_rst(soft_rst),
    .wr4_en(in_exec & op_wr4),
    .wr4_idx(operand[DM_IDX_W-1:0]),
    .wr4_data(operand[MEM4_DATA_LSB +: NIB_W]),
    .rd4_idx(operand[DM_IDX_W-1:0]),
    .rd4_data(rd4_data),
    .wr8_en(in_exec & op_wr8),
    .wr8_idx(operand[3:0]),
    .wr8_data(operand[MEM8_DATA_LSB +: 8]),
    .rd8_idx(operand[3:0]),
    .rd8_data(rd8_data),
    .stk_en(push & ~stk_fault),
    .stk_data(ret_addr[7:0]),
    .pair_zero(pair_zero),
    .pair_last(pair_last)
  );

  cps_ret_stack u_ret_stack (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .soft_rst(soft_rst),
    .push(push),
    .pop(pop),
    .push_hi(ret_addr[IA_W-1:8]),
    .touch_last(touch_last),
    .stack_depth(stack_depth),
    .stack_hi(stack_hi),
    .fault(stk_fault)
  );

endmodule : cps_sequencer

// file: dv/cps_seq_props.sv
// Port checker for the program sequencer
`timescale 1ns/10ps
module cps_seq_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Program memory, flags and fault
  input wire logic [cps_pkg::TP_W-1:0] prog_addr,
  input wire logic [cps_pkg::PW_W-1:0] prog_data,
  input wire logic carry_flag,
  input wire logic status_flag,
  input wire logic hang_reset
);
  import cps_pkg::*;
  // ---------------------------------------------------------------
  // Shadow state
  // ---------------------------------------------------------------
  logic depth;
  logic [10:0] opnd;
  wire cmd_acc = avs_write && !avs_waitrequest && avs_address == OFS_CMD && avs_byteenable[0];
  wire opnd_acc = avs_write && !avs_waitrequest && avs_address == OFS_OPERAND;
  wire [3:0] cmd_op = avs_writedata[3:0];
  wire fault_cmd = cmd_acc && ((cmd_op == OP_CALL && depth) || (cmd_op == OP_RET && !depth));
  wire next_depth = (cmd_op == OP_CALL) ? !depth : ((cmd_op == OP_RET) ? 1'b0 : depth);
  wire jump_ok = (cmd_op == OP_BRANCH_ALWAYS || (cmd_op == OP_CALL && !depth)) && {1'b0, opnd} < TEST_BASE;
  // Depth is predicted from bus traffic alone, so faults are known without peeking inside
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      depth <= 1'b0;
      opnd <= 11'h000;
    end else begin
      if (cmd_acc) depth <= next_depth;
      if (opnd_acc) opnd <= avs_writedata[10:0];
    end
  end
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  chk_reset_addr: assert property ($rose(rst_n) |-> prog_addr == 12'h000)
    else $error("program address not zero after reset");
  chk_addr_moves: assert property ($changed(prog_addr) |-> ($past(cmd_acc) || $past(cmd_acc, 2)))
    else $error("program address moved without a command");
  chk_jump_target: assert property (cmd_acc && jump_ok |-> ##2 prog_addr == {1'b0, opnd})
    else $error("jump target not loaded");
  chk_table_keeps: assert property (cmd_acc && cmd_op == OP_TABLE ##1 prog_addr < TEST_BASE
    |=> prog_addr == $past(prog_addr, 2))
    else $error("table read moved the instruction address");
  chk_test_redirect: assert property (cmd_acc |-> ##2 prog_addr < TEST_BASE)
    else $error("fetch inside reserved region");
  chk_hang_pulse: assert property (hang_reset |=> !hang_reset)
    else $error("hang pulse longer than one cycle");
  chk_fault_hang: assert property (fault_cmd |-> ##[1:3] hang_reset)
    else $error("stack fault without hang pulse");
  chk_no_false_hang: assert property (cmd_acc && !fault_cmd |-> ##1 !hang_reset [*3])
    else $error("hang pulse without stack fault");
endmodule : cps_seq_props

// file: dv/cps_prog_mem.sv
// Program memory model with asynchronous read
`timescale 1ns/10ps
module cps_prog_mem (
  // Program port
  input wire logic [cps_pkg::TP_W-1:0] prog_addr,
  output logic [cps_pkg::PW_W-1:0] prog_data
);
  import cps_pkg::*;
  // Each word is the low 10 address bits XOR 2a5 hex with the top two bits folded in; no test program is loaded in the reserved region
  assign prog_data = prog_addr[9:0] ^ 10'h2a5 ^ {8'h00, prog_addr[11:10]};
endmodule : cps_prog_mem

// file: dv/testbench.sv
// Self-checking testbench of the program sequencer
`timescale 1ns/10ps
module testbench;
  import cps_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [11:0] prog_addr;
  logic [9:0] prog_data;
  logic carry_flag = 1'b0;
  logic status_flag = 1'b0;
  logic hang_reset;
  logic [10:0] ia;
  logic [10:0] tgt;
  logic [3:0] op;
  int mismatches = 0;
  int num_checks = 0;
  always #5 sys_clk = !sys_clk;
  cps_sequencer i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .prog_addr(prog_addr),
    .prog_data(prog_data), .carry_flag(carry_flag), .status_flag(status_flag), .hang_reset(hang_reset));
  cps_prog_mem i_mem (.prog_addr(prog_addr), .prog_data(prog_data));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  function automatic logic [9:0] pw(input logic [11:0] a);
    return a[9:0] ^ 10'h2a5 ^ {8'h00, a[11:10]};
  endfunction : pw
  task automatic test_done();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic hang_out();
    mismatches++;
    $display("ERROR %0t: no answer", $time);
    test_done();
  endtask : hang_out
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [5:0] adr, input logic [31:0] dat, output logic [31:0] rdat);
    int n;
    logic w;
    @(posedge sys_clk);
    avs_address <= adr;
    avs_writedata <= dat;
    avs_write <= wr;
    avs_read <= !wr;
    // Waitrequest is combinational on state that moves at the edge, so it is read before the edge
    for (n = 0; n < 50; n++) begin
      @(negedge sys_clk);
      w = avs_waitrequest;
      @(posedge sys_clk);
      if (w === 1'b0) break;
    end
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n == 50) hang_out();
  endtask : bus
  task automatic wr(input logic [5:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    bus(1'b1, adr, dat, d);
  endtask : wr
  task automatic rd_chk(input logic [5:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, adr, 32'h0000_0000, d);
    check(d, exp);
  endtask : rd_chk
  // Waits for busy to fall so the next operand write is never stalled mid-command
  task automatic cmd(input logic [3:0] code, input logic [11:0] opnd);
    logic [31:0] d;
    int n;
    wr(OFS_OPERAND, 32'(opnd));
    wr(OFS_CMD, 32'(code));
    for (n = 0; n < 20; n++) begin
      bus(1'b0, OFS_STATUS, 32'h0000_0000, d);
      if (d[ST_BUSY_BIT] === 1'b0) break;
    end
    if (n == 20) hang_out();
  endtask : cmd
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd_chk(OFS_INSTR, 32'h0000_0000);
    rd_chk(OFS_STATUS, 32'h0000_0000);
    rd_chk(OFS_TABLE_PTR, 32'h0000_0000);
    cmd(OP_NOP, 12'h000);
    cmd(OP_STEP, 12'h003);
    rd_chk(OFS_INSTR, 32'h0000_0004);
    rd_chk(OFS_FETCH, 32'(pw(12'h004)));
    ia = 11'h004;
    for (int i = 0; i < 10; i++) begin
      op = OP_BRANCH_ALWAYS + 4'(i / 2);
      tgt = 11'h100 + 11'(i * 16);
      carry_flag <= i[0];
      status_flag <= i[0];
      ia = (op == OP_BRANCH_ALWAYS || op[0] == i[0]) ? tgt : ia + 11'h002;
      cmd(op, {1'b0, tgt});
      rd_chk(OFS_INSTR, 32'(ia));
    end
    cmd(OP_CALL, 12'h300);
    rd_chk(OFS_INSTR, 32'h0000_0300);
    rd_chk(OFS_STATUS, 32'h0000_0001);
    rd_chk(OFS_RET_STACK, 32'(ia + 11'h002));
    cmd(OP_RET, 12'h000);
    rd_chk(OFS_INSTR, 32'(ia + 11'h002));
    wr(OFS_STATUS, 32'h0000_0001);
    rd_chk(OFS_STATUS, 32'h0000_0000);
    rd_chk(OFS_RET_STACK, 32'(ia + 11'h002));
    cmd(OP_RET, 12'h000);
    rd_chk(OFS_INSTR, 32'h0000_0000);
    rd_chk(OFS_STATUS, 32'h0000_0004);
    wr(OFS_STATUS, 32'h0000_0004);
    cmd(OP_CALL, 12'h200);
    cmd(OP_CALL, 12'h400);
    rd_chk(OFS_INSTR, 32'h0000_0000);
    rd_chk(OFS_STATUS, 32'h0000_0004);
    rd_chk(OFS_RET_STACK, 32'h0000_0002);
    wr(OFS_STATUS, 32'h0000_0004);
    cmd(OP_WR4, 12'ha11);
    cmd(OP_WR8, 12'h5c0);
    cmd(OP_RD4, 12'h010);
    rd_chk(OFS_MEM_DATA, 32'h0000_0005);
    wr(OFS_CTRL_ZERO, 32'h0000_0030);
    rd_chk(OFS_TABLE_PTR, 32'h0000_035c);
    cmd(OP_TABLE, 12'h000);
    rd_chk(OFS_TABLE_DATA, 32'(pw(12'h35c)));
    rd_chk(OFS_INSTR, 32'h0000_0003);
    cmd(OP_ACC_LOAD, 12'h007);
    rd_chk(OFS_ACC, 32'h0000_0007);
    cmd(OP_ACC_FROM_MEM, 12'h010);
    rd_chk(OFS_ACC, 32'h0000_0005);
    cmd(OP_WR4, 12'h301);
    cmd(OP_RD8, 12'h001);
    rd_chk(OFS_MEM_DATA, 32'h0000_00a3);
    // User code stays below the reserved region; the jump below lands one short of its edge and the step after it crosses in
    cmd(OP_BRANCH_ALWAYS, 12'h7e9);
    cmd(OP_NOP, 12'h000);
    rd_chk(OFS_INSTR, 32'h0000_0000);
    rd_chk(OFS_STATUS, 32'h0000_0008);
    wr(OFS_STATUS, 32'h0000_0008);
    wr(OFS_CTRL_ZERO, 32'h0000_0070);
    cmd(OP_WR8, 12'hf00);
    cmd(OP_TABLE, 12'h000);
    rd_chk(OFS_INSTR, 32'h0000_0000);
    rd_chk(OFS_TABLE_DATA, 32'(pw(12'h35c)));
    wr(6'h3c, 32'hffff_ffff);
    rd_chk(OFS_TABLE_PTR, 32'h0000_07f0);
    wr(OFS_STATUS, 32'h0000_0008);
    cmd(OP_CALL, 12'h100);
    cmd(OP_WR8, 12'h3cf);
    rd_chk(OFS_RET_STACK, 32'h0000_073c);
    cmd(OP_RET, 12'h000);
    rd_chk(OFS_INSTR, 32'h0000_073c);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd_chk(OFS_INSTR, 32'h0000_0000);
    rd_chk(OFS_TABLE_PTR, 32'h0000_0000);
    rd_chk(OFS_RET_STACK, 32'h0000_073c);
    rd_chk(OFS_ACC, 32'h0000_0005);
    cmd(OP_RD8, 12'h001);
    rd_chk(OFS_MEM_DATA, 32'h0000_00a3);
    test_done();
  end
endmodule : testbench
bind cps_sequencer cps_seq_props i_props (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .prog_addr(prog_addr),
  .prog_data(prog_data), .carry_flag(carry_flag), .status_flag(status_flag), .hang_reset(hang_reset));
